/* File: rtl/pio_pkg.sv */
/*
  Constants for the parallel port bank: register offsets, implemented-bit masks and reset values.
  Assumes a byte-wide processor bus with a 4-bit address.
*/
// Operation
// - Fifty pins in parallel ports, each settable as input or output.
// - Data A-D at 0x00-0x03, direction A-D 0x04-0x07, E-H 0x08-0x0F.
// - Direction one drives the latch onto the pin; zero leaves it high impedance.
// - Reset clears port A and B direction registers.
// - Reset leaves port A data latches unchanged.
// - Data read returns latch for bits whose direction is one.
// - Data read returns synchronised pin level for bits whose direction is zero.
// - Data writes always update latches whatever the direction.
// - Direction registers are plain read/write storage.
// - Channel select takes a port B pin as analog; direction then ignored.
// - Analog port B bit reads zero if input, latch if output.
// - Port C has six data bits; bits 7 and 6 read zero; reset keeps them.
// - Clock output enable, direction bit 7, drives system clock on port C pin 2.
// - Port F has bits 6-0, port G 2-0, port H 1-0; others read zero.
// - Clock output enable overrides direction bit 2; reset clears it.
// - Reset clears all port C direction bits.
package pio_pkg;
    localparam logic [3:0] PIO_OFF_DATA_A = 4'h0;
    localparam logic [3:0] PIO_OFF_DATA_B = 4'h1;
    localparam logic [3:0] PIO_OFF_DATA_C = 4'h2;
    localparam logic [3:0] PIO_OFF_DATA_D = 4'h3;
    localparam logic [3:0] PIO_OFF_DIR_A = 4'h4;
    localparam logic [3:0] PIO_OFF_DIR_B = 4'h5;
    localparam logic [3:0] PIO_OFF_DIR_C = 4'h6;
    localparam logic [3:0] PIO_OFF_DIR_D = 4'h7;
    localparam logic [3:0] PIO_OFF_DATA_E = 4'h8;
    localparam logic [3:0] PIO_OFF_DATA_F = 4'h9;
    localparam logic [3:0] PIO_OFF_DATA_G = 4'hA;
    localparam logic [3:0] PIO_OFF_DATA_H = 4'hB;
    localparam logic [3:0] PIO_OFF_DIR_E = 4'hC;
    localparam logic [3:0] PIO_OFF_DIR_F = 4'hD;
    localparam logic [3:0] PIO_OFF_DIR_G = 4'hE;
    localparam logic [3:0] PIO_OFF_DIR_H = 4'hF;
    // Implemented-bit masks per port index A..H
    localparam logic [7:0] PIO_MASK_DATA_C = 8'h3F;
    localparam logic [7:0] PIO_MASK_DIR_C = 8'hBF;
    localparam logic [7:0] PIO_MASK_F = 8'h7F;
    localparam logic [7:0] PIO_MASK_G = 8'h07;
    localparam logic [7:0] PIO_MASK_H = 8'h03;
    localparam logic [7:0] PIO_MASK_FULL = 8'hFF;
    localparam int PIO_CLKOUT_BIT = 7;
    localparam int PIO_CLKOUT_PIN = 2;
    localparam logic [7:0] PIO_DIR_RESET = 8'h00;
    localparam int PIO_NUM_PORTS = 8;
    localparam int PIO_CH_W = 5;
endpackage

/* File: rtl/pio_ports.sv */
/*
  Bank of eight memory-mapped parallel ports with data latches, direction registers,
  analog channel override on port B and system clock output on port C pin 2.
  Assumes a byte-wide processor bus on clk: bus_wr/bus_rd are one-cycle strobes,
  read data is registered and valid the cycle after bus_rd.
*/
`timescale 1ns/1ps
module pio_ports (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [4:0] converter_channel_select,
    input wire logic [63:0] pin_in,
    output logic [63:0] pin_out,
    output logic [63:0] pin_oe,
    output logic clock_output_enable
);
    logic [7:0] data_r [pio_pkg::PIO_NUM_PORTS];
    logic [7:0] dir_r [pio_pkg::PIO_NUM_PORTS];
    logic [7:0] level [pio_pkg::PIO_NUM_PORTS];
    logic [7:0] rdata_r;
    logic [63:0] pin_out_r;
    logic [63:0] pin_oe_r;
    logic clkout_r;
    logic [7:0] rd_mux;
    logic [7:0] analog_b;
    logic [2:0] sel_port;
    logic sel_dir;
    logic [63:0] out_nxt;
    logic [63:0] oe_nxt;

    // Offset to port index: bit 3 picks bank A-D or E-H, bit 2 picks data or direction
    function automatic logic [2:0] port_index(input logic [3:0] a);
        port_index = {a[3], a[1:0]};
    endfunction

    function automatic logic [7:0] data_mask(input logic [2:0] p);
        case (p)
            3'h2: data_mask = pio_pkg::PIO_MASK_DATA_C;
            3'h5: data_mask = pio_pkg::PIO_MASK_F;
            3'h6: data_mask = pio_pkg::PIO_MASK_G;
            3'h7: data_mask = pio_pkg::PIO_MASK_H;
            default: data_mask = pio_pkg::PIO_MASK_FULL;
        endcase
    endfunction

    function automatic logic [7:0] dir_mask(input logic [2:0] p);
        if (p == 3'h2) begin
            dir_mask = pio_pkg::PIO_MASK_DIR_C;
        end else begin
            dir_mask = data_mask(p);
        end
    endfunction

    assign sel_port = port_index(bus_addr);
    assign sel_dir = bus_addr[2];

    // Channels 0..7 map onto port B pins; larger codes leave every port B pin digital
    assign analog_b = (converter_channel_select < 5'h08) ?
                      (8'h01 << converter_channel_select[2:0]) : 8'h00;

    genvar g;
    generate
        for (g = 0; g < pio_pkg::PIO_NUM_PORTS; g++) begin : g_port
            pio_sync u_sync (
                .clk(clk),
                .rst(rst),
                .pin_in(pin_in[g*8 +: 8]),
                .level(level[g])
            );
        end
    endgenerate

    // Read value for the selected port
    logic [7:0] rd_data_val;
    logic [7:0] rd_dir;
    assign rd_dir = dir_r[sel_port] & dir_mask(sel_port);
    assign rd_data_val = ((rd_dir & data_r[sel_port]) |
                          (~rd_dir & level[sel_port] &
                           ((sel_port == 3'h1) ? ~analog_b : 8'hFF))) & data_mask(sel_port);
    assign rd_mux = sel_dir ? rd_dir : rd_data_val;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // Data latches have no reset: reset leaves them as they were
    always_ff @(posedge clk) begin
        if (bus_wr && !sel_dir) begin
            data_r[sel_port] <= bus_wdata & data_mask(sel_port);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < pio_pkg::PIO_NUM_PORTS; i++) begin
                dir_r[i] <= pio_pkg::PIO_DIR_RESET;
            end
        end else if (bus_wr && sel_dir) begin
            dir_r[sel_port] <= bus_wdata & dir_mask(sel_port);
        end
    end

    // Pin drive: direction gates the buffer except where an alternate function owns it
    always_comb begin
        out_nxt = 64'h0;
        oe_nxt = 64'h0;
        for (int i = 0; i < pio_pkg::PIO_NUM_PORTS; i++) begin
            out_nxt[i*8 +: 8] = data_r[i] & data_mask(3'(i));
            oe_nxt[i*8 +: 8] = dir_r[i] & data_mask(3'(i));
        end
        oe_nxt[15:8] = dir_r[1] & ~analog_b;
        if (dir_r[2][pio_pkg::PIO_CLKOUT_BIT]) begin
            oe_nxt[16 + pio_pkg::PIO_CLKOUT_PIN] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_r <= 64'h0;
            pin_oe_r <= 64'h0;
            clkout_r <= 1'b0;
        end else begin
            pin_out_r <= out_nxt;
            pin_oe_r <= oe_nxt;
            clkout_r <= dir_r[2][pio_pkg::PIO_CLKOUT_BIT];
        end
    end

    // Clock pin must toggle at clk rate, so it is muxed here from the registered enable
    logic [63:0] pin_out_mux;
    always_comb begin
        pin_out_mux = pin_out_r;
        pin_out_mux[16 + pio_pkg::PIO_CLKOUT_PIN] = clkout_r ? clk : pin_out_r[16 + pio_pkg::PIO_CLKOUT_PIN];
    end

    assign bus_rdata = rdata_r;
    assign pin_out = pin_out_mux;
    assign pin_oe = pin_oe_r;
    assign clock_output_enable = clkout_r;

    property p_dir_reset;
        @(posedge clk) rst |=> (dir_r[0] == 8'h00 && dir_r[1] == 8'h00 && dir_r[2] == 8'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

    property p_oe_follows;
        @(posedge clk) disable iff (rst)
        (bus_wr && bus_addr == pio_pkg::PIO_OFF_DIR_A) |=> ##1 (pin_oe[7:0] == $past(bus_wdata, 2));
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("port A enable wrong");

    property p_rd_dir;
        @(posedge clk) disable iff (rst)
        (bus_rd && bus_addr == pio_pkg::PIO_OFF_DIR_A && !bus_wr) |=> (bus_rdata == $past(dir_r[0]));
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

    property p_rd_c_top;
        @(posedge clk) disable iff (rst)
        $past(bus_rd && bus_addr == pio_pkg::PIO_OFF_DATA_C) |-> (bus_rdata[7:6] == 2'b00);
    endproperty
    a_rd_c_top: assert property (p_rd_c_top) else $error("port C top bits not zero");

    property p_rd_h;
        @(posedge clk) disable iff (rst)
        $past(bus_rd && bus_addr == pio_pkg::PIO_OFF_DIR_H) |-> (bus_rdata[7:2] == 6'h00);
    endproperty
    a_rd_h: assert property (p_rd_h) else $error("port H unimplemented bits set");

    property p_unimpl_g;
        @(posedge clk) disable iff (rst) (dir_r[6][7:3] == 5'h00 && dir_r[2][6] == 1'b0);
    endproperty
    a_unimpl_g: assert property (p_unimpl_g) else $error("unimplemented bit stored");

    property p_analog_oe;
        @(posedge clk) disable iff (rst)
        (converter_channel_select < 5'h08 && $stable(converter_channel_select)) |->
        ((pin_oe[15:8] & analog_b) == 8'h00);
    endproperty
    a_analog_oe: assert property (p_analog_oe) else $error("analog pin driven");

    property p_clk_oe;
        @(posedge clk) disable iff (rst) clock_output_enable |-> pin_oe[18];
    endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock pin not driven");

    property p_wr_data;
        @(posedge clk) disable iff (rst)
        (bus_wr && bus_addr == pio_pkg::PIO_OFF_DATA_A) |=> (data_r[0] == $past(bus_wdata));
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data latch not written");

    // Writes land in the register at the strobe edge and reach the pins one edge later
    sequence s_dir_b_write;
        bus_wr && bus_addr == pio_pkg::PIO_OFF_DIR_B;
    endsequence

    sequence s_dir_c_write;
        bus_wr && bus_addr == pio_pkg::PIO_OFF_DIR_C;
    endsequence

    sequence s_dir_h_write;
        bus_wr && bus_addr == pio_pkg::PIO_OFF_DIR_H;
    endsequence

    sequence s_data_a_write;
        bus_wr && bus_addr == pio_pkg::PIO_OFF_DATA_A;
    endsequence

    sequence s_pins_released;
        (pin_oe == 64'h0 && !clock_output_enable) [*2];
    endsequence

    property p_pins_reset;
        @(posedge clk) rst |=> s_pins_released;
    endproperty
    a_pins_reset: assert property (p_pins_reset) else $error("pins not released by reset");

    property p_oe_b_follows;
        @(posedge clk) disable iff (rst)
        s_dir_b_write |=> ##1 (pin_oe[15:8] == ($past(bus_wdata, 2) & ~$past(analog_b)));
    endproperty
    a_oe_b_follows: assert property (p_oe_b_follows) else $error("port B enable wrong");

    property p_oe_c_follows;
        @(posedge clk) disable iff (rst)
        s_dir_c_write |=> ##1
        (pin_oe[21:16] == ($past(bus_wdata[5:0], 2) | {3'h0, $past(bus_wdata[pio_pkg::PIO_CLKOUT_BIT], 2), 2'h0}));
    endproperty
    a_oe_c_follows: assert property (p_oe_c_follows) else $error("port C enable wrong");

    property p_oe_h_follows;
        @(posedge clk) disable iff (rst)
        s_dir_h_write |=> ##1 (pin_oe[63:56] == ($past(bus_wdata, 2) & pio_pkg::PIO_MASK_H));
    endproperty
    a_oe_h_follows: assert property (p_oe_h_follows) else $error("port H enable wrong");

    property p_out_a_follows;
        @(posedge clk) disable iff (rst)
        s_data_a_write |=> ##1 (pin_out[7:0] == $past(bus_wdata, 2));
    endproperty
    a_out_a_follows: assert property (p_out_a_follows) else $error("port A pin value wrong");

    property p_clkout_follows;
        @(posedge clk) disable iff (rst)
        s_dir_c_write |=> ##1 (clock_output_enable == $past(bus_wdata[pio_pkg::PIO_CLKOUT_BIT], 2));
    endproperty
    a_clkout_follows: assert property (p_clkout_follows) else $error("clock enable wrong");

    property p_unimpl_pins;
        @(posedge clk) disable iff (rst)
        (pin_oe[23:22] == 2'h0 && pin_oe[47] == 1'h0 && pin_oe[55:51] == 5'h00 && pin_oe[63:58] == 6'h00 &&
         pin_out[23:22] == 2'h0 && pin_out[47] == 1'h0 && pin_out[55:51] == 5'h00 && pin_out[63:58] == 6'h00);
    endproperty
    a_unimpl_pins: assert property (p_unimpl_pins) else $error("unimplemented pin driven");

    property p_rd_data_a;
        @(posedge clk) disable iff (rst)
        (bus_rd && !bus_wr && bus_addr == pio_pkg::PIO_OFF_DATA_A) |=>
        (bus_rdata == (($past(dir_r[0]) & $past(data_r[0])) | (~$past(dir_r[0]) & $past(level[0]))));
    endproperty
    a_rd_data_a: assert property (p_rd_data_a) else $error("port A data read wrong");

    property p_rd_b_analog;
        @(posedge clk) disable iff (rst)
        (bus_rd && !bus_wr && bus_addr == pio_pkg::PIO_OFF_DATA_B) |=>
        ((bus_rdata & $past(analog_b) & ~$past(dir_r[1])) == 8'h00);
    endproperty
    a_rd_b_analog: assert property (p_rd_b_analog) else $error("analog input bit not zero");

    property p_rd_f_top;
        @(posedge clk) disable iff (rst)
        $past(bus_rd && (bus_addr == pio_pkg::PIO_OFF_DATA_F || bus_addr == pio_pkg::PIO_OFF_DIR_F)) |->
        (bus_rdata[7] == 1'h0);
    endproperty
    a_rd_f_top: assert property (p_rd_f_top) else $error("port F top bit set");

    property p_rd_g;
        @(posedge clk) disable iff (rst)
        $past(bus_rd && (bus_addr == pio_pkg::PIO_OFF_DATA_G || bus_addr == pio_pkg::PIO_OFF_DIR_G)) |->
        (bus_rdata[7:3] == 5'h00);
    endproperty
    a_rd_g: assert property (p_rd_g) else $error("port G unimplemented bits set");

    property p_rd_c_dir6;
        @(posedge clk) disable iff (rst)
        $past(bus_rd && bus_addr == pio_pkg::PIO_OFF_DIR_C) |-> (bus_rdata[6] == 1'h0);
    endproperty
    a_rd_c_dir6: assert property (p_rd_c_dir6) else $error("port C direction bit 6 set");

    property p_wr_data_c;
        @(posedge clk) disable iff (rst)
        (bus_wr && bus_addr == pio_pkg::PIO_OFF_DATA_C) |=>
        (data_r[2] == ($past(bus_wdata) & pio_pkg::PIO_MASK_DATA_C));
    endproperty
    a_wr_data_c: assert property (p_wr_data_c) else $error("port C latch wrong");

    property p_rdata_stands;
        @(posedge clk) disable iff (rst)
        !bus_rd |=> $stable(bus_rdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed without read");

    // A synchronised level may only move to what the pin showed four cycles earlier
    property p_level_a;
        @(posedge clk) disable iff (rst)
        $changed(level[0]) |-> (((level[0] ^ $past(level[0])) & (level[0] ^ $past(pin_in[7:0], 4))) == 8'h00);
    endproperty
    a_level_a: assert property (p_level_a) else $error("pin level not synchronised");
endmodule // pio_ports

/* File: rtl/pio_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter for one 8-bit port.
  Assumes asynchronous pin levels and a single clock.
*/
`timescale 1ns/1ps
module pio_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] pin_in,
    output logic [7:0] level
);
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s3_r;
    logic [7:0] level_r;
    logic [7:0] agree;
    logic [7:0] level_nxt;

    assign agree = ~(s2_r ^ s3_r);
    assign level_nxt = (agree & s3_r) | (~agree & level_r);
    assign level = level_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
            level_r <= 8'h00;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end
endmodule // pio_sync

/* File: verification/parallel_io_ports_tb_top.sv */
/*
  Self-checking bench for the parallel port bank: registers, pin direction, analog and clock override.
  Assumes the strobe bus of the design, read data one cycle after the strobe, and a pin model.
*/
`timescale 1ns/1ps
module parallel_io_ports_tb_top;
    logic clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, clk_oe;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00, bus_rdata;
    logic [4:0] ch_sel = 5'h1F;
    logic [63:0] pin_in, pin_out, pin_oe, board = 64'hA55A_3CC3_0FF0_9669;
    int miscompares = 0, comparisons = 0;
    always #20 clk = ~clk;
    pio_ports DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .converter_channel_select(ch_sel),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .clock_output_enable(clk_oe));
    pio_pins_model board_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board), .pin_in(pin_in));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] doff(input int p);
        return 4'(p < 4 ? p : p + 4);
    endfunction
    function automatic logic [7:0] msk(input int p, input bit dir);
        case (p)
            2: return dir ? pio_pkg::PIO_MASK_DIR_C : pio_pkg::PIO_MASK_DATA_C;
            5: return pio_pkg::PIO_MASK_F;
            6: return pio_pkg::PIO_MASK_G;
            7: return pio_pkg::PIO_MASK_H;
            default: return pio_pkg::PIO_MASK_FULL;
        endcase
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        #1;
        check(bus_rdata, e);
    endtask
    // Pins land two edges after a write; board levels need the synchroniser to settle
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        for (int p = 0; p < 8; p++) rdc(doff(p) + 4'h4, 8'h00);
        check(pin_oe, 64'h0);
        check({63'h0, clk_oe}, 64'h0);
    endtask
    task automatic t_input;
        settle(8);
        for (int p = 0; p < 8; p++) rdc(doff(p), board[p*8+:8] & msk(p, 0));
        for (int p = 0; p < 8; p++) wr(doff(p), ~board[p*8+:8]);
        for (int p = 0; p < 8; p++) rdc(doff(p), board[p*8+:8] & msk(p, 0));
        check(pin_oe, 64'h0);
    endtask
    task automatic t_output;
        logic [63:0] m;
        logic hi;
        for (int p = 0; p < 8; p++) m[p*8+:8] = msk(p, 0);
        for (int p = 0; p < 8; p++) wr(doff(p) + 4'h4, 8'hFF);
        for (int p = 0; p < 8; p++) rdc(doff(p) + 4'h4, msk(p, 1));
        for (int p = 0; p < 8; p++) rdc(doff(p), ~board[p*8+:8] & msk(p, 0));
        settle(2);
        check(pin_oe, m);
        check(pin_out & ~64'h4_0000, ~board & m & ~64'h4_0000);
        hi = pin_out[18];
        @(negedge clk);
        #1;
        check({clk_oe, hi, pin_out[18]}, 3'b110);
        wr(4'h6, 8'h80);
        settle(2);
        check({clk_oe, pin_oe[23:16]}, 9'h104);
        wr(4'h6, 8'h3F);
        settle(2);
        check({clk_oe, pin_oe[23:16], pin_out[18]}, {1'b0, 8'h3F, ~board[18]});
    endtask
    task automatic t_analog;
        @(posedge clk);
        ch_sel <= 5'h03;
        board <= board | 64'h800;
        rdc(4'h1, 8'h69);
        check(pin_oe[15:8], 8'hF7);
        wr(4'h5, 8'hF7);
        settle(8);
        check(pin_oe[15:8], 8'hF7);
        rdc(4'h1, 8'h61);
        @(posedge clk);
        ch_sel <= 5'h1F;
        rdc(4'h1, 8'h69);
    endtask
    task automatic t_keep;
        wr(4'h0, 8'h5A);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check(pin_oe, 64'h0);
        wr(4'h4, 8'hFF);
        wr(4'h6, 8'h3F);
        rdc(4'h0, 8'h5A);
        rdc(4'h2, 8'h0F);
    endtask
    task automatic results;
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_input();
        t_output();
        t_analog();
        t_keep();
        results();
    end
    // The run needs well under a thousand cycles; five thousand means a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule // parallel_io_ports_tb_top

/* File: verification/pio_pins_model.sv */
/*
  Board-side pin model: each pin carries the port's value while it drives, else the board level.
  Assumes the board releases any pin that the port bank drives, so there is no contention.
*/
`timescale 1ns/1ps
module pio_pins_model (
    input wire logic [63:0] pin_out,
    input wire logic [63:0] pin_oe,
    input wire logic [63:0] board_level,
    output logic [63:0] pin_in
);
    assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule // pio_pins_model
